//--- verilog/ccp_route_pkg.sv
package ccp_route_pkg;
    // Register indices, byte address is four times the index
    localparam int unsigned NUM_REGS = 12;
    localparam logic [3:0] IDX_CH1_CTRL = 4'h0;
    localparam logic [3:0] IDX_CH1_LOW = 4'h1;
    localparam logic [3:0] IDX_CH1_HIGH = 4'h2;
    localparam logic [3:0] IDX_CH2_CTRL = 4'h3;
    localparam logic [3:0] IDX_CH2_LOW = 4'h4;
    localparam logic [3:0] IDX_CH2_HIGH = 4'h5;
    localparam logic [3:0] IDX_CH3_CTRL = 4'h6;
    localparam logic [3:0] IDX_CH3_LOW = 4'h7;
    localparam logic [3:0] IDX_CH3_HIGH = 4'h8;
    localparam logic [3:0] IDX_T3_CTRL = 4'h9;
    localparam logic [3:0] IDX_CONFIG = 4'hA;
    localparam logic [3:0] IDX_STATUS = 4'hB;
    // Registers per channel and channel count
    localparam int unsigned REGS_PER_CHAN = 3;
    localparam int unsigned NUM_CHAN = 3;
    // Channel control field layout
    localparam logic [7:0] CTRL_MASK = 8'h3F;
    localparam int unsigned CTRL_DUTY_LSB = 4;
    localparam int unsigned CTRL_MODE_LSB = 0;
    // Mode values
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
    // Timer3 control select bit positions
    localparam int unsigned T3_SEL_HI_BIT = 6;
    localparam int unsigned T3_SEL_LO_BIT = 3;
    // Own configuration register layout
    localparam int unsigned CFG_PIN_SEL_BIT = 0;
    localparam int unsigned CFG_EXT_MEM_BIT = 1;
    localparam int unsigned CFG_PINS80_BIT = 2;
    localparam logic [7:0] CFG_MASK = 8'h07;
    localparam logic [7:0] CFG_RESET = 8'h01;
    // Status register layout
    localparam int unsigned STAT_ROUTE_LSB = 0;
    localparam int unsigned STAT_PIN_LSB = 4;
    // Generic reset value
    localparam logic [7:0] REG_RESET = 8'h00;
    // Timer one-hot codes {timer3, timer2, timer1}
    localparam logic [2:0] TMR_NONE = 3'h0;
    localparam logic [2:0] TMR_1 = 3'h1;
    localparam logic [2:0] TMR_2 = 3'h2;
    localparam logic [2:0] TMR_3 = 3'h4;
    // Channel-2 pin one-hot codes {portb3, porte7, portc1}
    localparam logic [2:0] PIN_C1 = 3'h1;
    localparam logic [2:0] PIN_E7 = 3'h2;
    localparam logic [2:0] PIN_B3 = 3'h4;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Routing configurations, one-hot
    typedef enum logic [3:0] {
        ROUTE_ALL_T1 = 4'b0001,
        ROUTE_CH1_T1 = 4'b0010,
        ROUTE_CH12_T1 = 4'b0100,
        ROUTE_ALL_T3 = 4'b1000
    } route_e;
endpackage

//--- verilog/ccp_timer_and_pin_routing.sv
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - Three channels: control, data low, data high
// - All channel registers read and write
// - Capture/compare uses timer1/3, PWM timer2
// - Timer choice from timer3 control select bits
// - Channels run together, sharing timers
// - Up to three timers serve at once
// - Config one: timer1 all, timer3 unused
// - Config two: timer1 ch1, timer3 ch2-3
// - Config three: timer1 ch1-2, timer3 ch3
// - Config four: timer3 all, timer1 unused
// - Pin select one gives port C pin
// - Alternate pin: E7, or B3 external 80-pin
// - Unimplemented channel control and config bits read as zero; timer3 control keeps all eight
module ccp_timer_and_pin_routing (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Per-channel settings to the engines, channel n at slice n-1
    output logic [11:0] chanMode,
    output logic [5:0] chanDuty,
    output logic [47:0] chanData,
    // Per-channel time base, one-hot {timer3, timer2, timer1}
    output logic [8:0] chanTimerSel,
    // Channel-2 engine side
    input wire logic chan2OutLevel,
    output logic chan2CaptureIn,
    // Port pins offered to channel 2
    input wire logic portcPin1In,
    input wire logic portePin7In,
    input wire logic portbPin3In,
    output logic portcPin1Owned,
    output logic portePin7Owned,
    output logic portbPin3Owned,
    output logic portcPin1Data,
    output logic portePin7Data,
    output logic portbPin3Data
);
    // Register storage, one byte per register
    logic [7:0] regQ [0:ccp_route_pkg::NUM_REGS-1];
    // Data-phase state of the bus
    logic wrPendQ;
    logic [3:0] wrIdxQ;
    logic wrHitQ;
    // Address-phase decode
    logic accessNow;
    logic [3:0] addrIdx;
    logic addrHit;
    // Routing state
    ccp_route_pkg::route_e routeQ;
    ccp_route_pkg::route_e routeD;
    logic [2:0] pinSelQ;
    logic [2:0] pinSelD;
    logic [8:0] timerSelQ;
    logic [8:0] timerSelD;
    logic captureQ;

    // Readable mask per register index
    function automatic logic [7:0] readMask(input logic [3:0] idx);
        logic [7:0] m;
        m = 8'hFF;
        case (idx)
            ccp_route_pkg::IDX_CH1_CTRL,
            ccp_route_pkg::IDX_CH2_CTRL,
            ccp_route_pkg::IDX_CH3_CTRL: begin
                m = ccp_route_pkg::CTRL_MASK;
            end
            ccp_route_pkg::IDX_CONFIG: begin
                m = ccp_route_pkg::CFG_MASK;
            end
            default: begin
                m = 8'hFF;
            end
        endcase
        return m;
    endfunction

    // Time base for one channel given its mode and capture timer
    function automatic logic [2:0] timerFor(input logic [3:0] mode,
                                            input logic useT3);
        logic [2:0] t;
        t = ccp_route_pkg::TMR_NONE;
        if (mode == ccp_route_pkg::MODE_OFF) begin
            t = ccp_route_pkg::TMR_NONE;
        end else if (mode[3:2] == ccp_route_pkg::MODE_PWM_TOP) begin
            t = ccp_route_pkg::TMR_2;
        end else if (useT3) begin
            t = ccp_route_pkg::TMR_3;
        end else begin
            t = ccp_route_pkg::TMR_1;
        end
        return t;
    endfunction

    // Address-phase decode of the word index
    assign accessNow = hsel && hready &&
        (htrans == ccp_route_pkg::HTRANS_NONSEQ);
    assign addrIdx = haddr[5:2];
    assign addrHit = (haddr[31:6] == 26'h0000000) &&
        (addrIdx < 4'(ccp_route_pkg::NUM_REGS));

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Latch write address phase for the data phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPendQ <= 1'b0;
            wrIdxQ <= 4'h0;
            wrHitQ <= 1'b0;
        end else if (hready) begin
            // Only lane 0 carries the byte
            wrPendQ <= accessNow && hwrite &&
                ((hsize == ccp_route_pkg::HSIZE_WORD) || (haddr[1:0] == 2'h0));
            wrIdxQ <= addrIdx;
            wrHitQ <= addrHit;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < ccp_route_pkg::NUM_REGS; i++) begin
                regQ[i] <= ccp_route_pkg::REG_RESET;
            end
            regQ[ccp_route_pkg::IDX_CONFIG] <= ccp_route_pkg::CFG_RESET;
        end else if (wrPendQ && wrHitQ &&
                     (wrIdxQ != ccp_route_pkg::IDX_STATUS)) begin
            // Masked bits stay zero
            regQ[wrIdxQ] <= hwdata[7:0] & readMask(wrIdxQ);
        end
    end

    // Status byte: route config and channel-2 pin
    function automatic logic [7:0] statusByte(input logic [3:0] r,
                                              input logic [2:0] p);
        logic [7:0] s;
        s = 8'h00;
        s[ccp_route_pkg::STAT_ROUTE_LSB +: 4] = r;
        s[ccp_route_pkg::STAT_PIN_LSB +: 3] = p;
        return s;
    endfunction

    // Read data captured at the address phase, with write forwarding
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (hready) begin
            if (accessNow && !hwrite && addrHit) begin
                if (addrIdx == ccp_route_pkg::IDX_STATUS) begin
                    hrdata <= {24'h000000, statusByte(routeQ, pinSelQ)};
                end else if (wrPendQ && wrHitQ && (wrIdxQ == addrIdx)) begin
                    // Write in flight to the same register
                    hrdata <= {24'h000000, hwdata[7:0] & readMask(addrIdx)};
                end else begin
                    hrdata <= {24'h000000, regQ[addrIdx]};
                end
            end else begin
                // Unmapped or idle reads as zero
                hrdata <= 32'h00000000;
            end
        end
    end

    // Decode of timer3 select bits into a routing config
    always_comb begin
        case ({regQ[ccp_route_pkg::IDX_T3_CTRL][ccp_route_pkg::T3_SEL_HI_BIT],
               regQ[ccp_route_pkg::IDX_T3_CTRL][ccp_route_pkg::T3_SEL_LO_BIT]})
            2'b00: begin
                routeD = ccp_route_pkg::ROUTE_ALL_T1;
            end
            2'b01: begin
                routeD = ccp_route_pkg::ROUTE_CH1_T1;
            end
            2'b10: begin
                routeD = ccp_route_pkg::ROUTE_CH12_T1;
            end
            default: begin
                routeD = ccp_route_pkg::ROUTE_ALL_T3;
            end
        endcase
    end

    // Per-channel time base from mode and routing
    always_comb begin
        logic t3Ch1;
        logic t3Ch2;
        logic t3Ch3;
        t3Ch1 = 1'b0;
        t3Ch2 = 1'b0;
        t3Ch3 = 1'b0;
        case (routeD)
            ccp_route_pkg::ROUTE_ALL_T1: begin
                t3Ch1 = 1'b0;
                t3Ch2 = 1'b0;
                t3Ch3 = 1'b0;
            end
            ccp_route_pkg::ROUTE_CH1_T1: begin
                t3Ch2 = 1'b1;
                t3Ch3 = 1'b1;
            end
            ccp_route_pkg::ROUTE_CH12_T1: begin
                t3Ch3 = 1'b1;
            end
            ccp_route_pkg::ROUTE_ALL_T3: begin
                t3Ch1 = 1'b1;
                t3Ch2 = 1'b1;
                t3Ch3 = 1'b1;
            end
            default: begin
                t3Ch1 = 1'b0;
            end
        endcase
        // Each channel decided on its own, so all may run
        timerSelD[2:0] =
            timerFor(regQ[ccp_route_pkg::IDX_CH1_CTRL][3:0], t3Ch1);
        timerSelD[5:3] =
            timerFor(regQ[ccp_route_pkg::IDX_CH2_CTRL][3:0], t3Ch2);
        timerSelD[8:6] =
            timerFor(regQ[ccp_route_pkg::IDX_CH3_CTRL][3:0], t3Ch3);
    end

    // Channel-2 pin choice from the configuration register
    always_comb begin
        logic [7:0] cfg;
        cfg = regQ[ccp_route_pkg::IDX_CONFIG];
        if (cfg[ccp_route_pkg::CFG_PIN_SEL_BIT]) begin
            pinSelD = ccp_route_pkg::PIN_C1;
        end else if (cfg[ccp_route_pkg::CFG_EXT_MEM_BIT] &&
                     cfg[ccp_route_pkg::CFG_PINS80_BIT]) begin
            pinSelD = ccp_route_pkg::PIN_B3;
        end else begin
            pinSelD = ccp_route_pkg::PIN_E7;
        end
    end

    // Routing state registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            routeQ <= ccp_route_pkg::ROUTE_ALL_T1;
            timerSelQ <= 9'h000;
            pinSelQ <= ccp_route_pkg::PIN_C1;
        end else begin
            routeQ <= routeD;
            timerSelQ <= timerSelD;
            pinSelQ <= pinSelD;
        end
    end

    // Pin data and capture path; direction stays with the port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            captureQ <= 1'b0;
            portcPin1Data <= 1'b0;
            portePin7Data <= 1'b0;
            portbPin3Data <= 1'b0;
        end else begin
            // Only the selected pin carries channel 2
            portcPin1Data <= chan2OutLevel & pinSelQ[0];
            portePin7Data <= chan2OutLevel & pinSelQ[1];
            portbPin3Data <= chan2OutLevel & pinSelQ[2];
            case (pinSelQ)
                ccp_route_pkg::PIN_C1: begin
                    captureQ <= portcPin1In;
                end
                ccp_route_pkg::PIN_E7: begin
                    captureQ <= portePin7In;
                end
                ccp_route_pkg::PIN_B3: begin
                    captureQ <= portbPin3In;
                end
                default: begin
                    captureQ <= 1'b0;
                end
            endcase
        end
    end

    // Ownership flags only steer data, never direction
    assign portcPin1Owned = pinSelQ[0];
    assign portePin7Owned = pinSelQ[1];
    assign portbPin3Owned = pinSelQ[2];
    assign chan2CaptureIn = captureQ;
    assign chanTimerSel = timerSelQ;

    // Settings straight from register flops
    always_comb begin
        for (int c = 0; c < ccp_route_pkg::NUM_CHAN; c++) begin
            chanMode[c*4 +: 4] =
                regQ[c*ccp_route_pkg::REGS_PER_CHAN]
                    [ccp_route_pkg::CTRL_MODE_LSB +: 4];
            chanDuty[c*2 +: 2] =
                regQ[c*ccp_route_pkg::REGS_PER_CHAN]
                    [ccp_route_pkg::CTRL_DUTY_LSB +: 2];
            chanData[c*16 +: 16] = {regQ[c*ccp_route_pkg::REGS_PER_CHAN + 2],
                                   regQ[c*ccp_route_pkg::REGS_PER_CHAN + 1]};
        end
    end

    // Checks
    property p_pwm_t2;
        @(posedge clk_sys) disable iff (rst)
        (chanMode[7:6] == 2'h3) |=> (chanTimerSel[5:3] == 3'h2);
    endproperty
    a_pwm_t2: assert property (p_pwm_t2)
        else $error("pwm channel 2 not on timer2");

    property p_onehot_route;
        @(posedge clk_sys) disable iff (rst)
        $onehot(routeQ);
    endproperty
    a_onehot_route: assert property (p_onehot_route)
        else $error("route config not one-hot");

    property p_cfg1;
        @(posedge clk_sys) disable iff (rst)
        (routeQ == ccp_route_pkg::ROUTE_ALL_T1) |->
            (chanTimerSel[2] == 1'b0 && chanTimerSel[5] == 1'b0 &&
             chanTimerSel[8] == 1'b0);
    endproperty
    a_cfg1: assert property (p_cfg1)
        else $error("timer3 used in config one");

    property p_cfg4;
        @(posedge clk_sys) disable iff (rst)
        (routeQ == ccp_route_pkg::ROUTE_ALL_T3) |->
            (chanTimerSel[0] == 1'b0 && chanTimerSel[3] == 1'b0 &&
             chanTimerSel[6] == 1'b0);
    endproperty
    a_cfg4: assert property (p_cfg4)
        else $error("timer1 used in config four");

    property p_cfg2;
        @(posedge clk_sys) disable iff (rst)
        (routeQ == ccp_route_pkg::ROUTE_CH1_T1) && $stable(routeQ) &&
            ($past(chanMode[7:6]) == 2'h1) |-> (chanTimerSel[5:3] == 3'h4);
    endproperty
    a_cfg2: assert property (p_cfg2)
        else $error("channel 2 not on timer3 in config two");

    property p_cfg3;
        @(posedge clk_sys) disable iff (rst)
        (routeQ == ccp_route_pkg::ROUTE_CH12_T1) && $stable(routeQ) &&
            ($past(chanMode[7:6]) == 2'h1) |-> (chanTimerSel[5:3] == 3'h1);
    endproperty
    a_cfg3: assert property (p_cfg3)
        else $error("channel 2 not on timer1 in config three");

    property p_pin_default;
        @(posedge clk_sys) disable iff (rst)
        regQ[ccp_route_pkg::IDX_CONFIG][0] |=>
            portcPin1Owned && !portePin7Owned;
    endproperty
    a_pin_default: assert property (p_pin_default)
        else $error("channel 2 not on port C pin");

    property p_pin_alt;
        @(posedge clk_sys) disable iff (rst)
        (regQ[ccp_route_pkg::IDX_CONFIG][2:0] == 3'h6) |=> portbPin3Owned;
    endproperty
    a_pin_alt: assert property (p_pin_alt)
        else $error("alternate pin not port B in external mode");

    property p_ctrl_zero;
        @(posedge clk_sys) disable iff (rst)
        regQ[ccp_route_pkg::IDX_CH2_CTRL][7:6] == 2'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("unimplemented control bits set");

    property p_write_read;
        @(posedge clk_sys) disable iff (rst)
        (wrPendQ && wrHitQ && wrIdxQ == ccp_route_pkg::IDX_CH1_LOW)
            |=> (chanData[7:0] == $past(hwdata[7:0]));
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("data low byte write lost");
endmodule

//--- test/ccp_far_side_model.sv
`timescale 1ns/100ps
// Far side of the block: port pins and the channel-2 engine
module ccp_far_side_model (
    // Clock
    input wire logic clk_sys,
    // Bench controls, pins as {B3, E7, C1}
    input wire logic [2:0] pinLevel,
    input wire logic [2:0] pinDirOut,
    input wire logic engineLevel,
    // Block side
    input wire logic [2:0] pinData,
    output logic [2:0] pinIn,
    output logic chan2OutLevel
);
    // Direction is owned by software, never by the pin routing
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            pinIn[k] = pinDirOut[k] ? pinData[k] : pinLevel[k];
        end
    end
    // Engine output stage, one flop like a real engine
    always_ff @(posedge clk_sys) begin
        chan2OutLevel <= engineLevel;
    end
endmodule

//--- test/test_ccp_timer_and_pin_routing.sv
`timescale 1ns/100ps
// Self-checking bench for the channel routing block
module test_ccp_timer_and_pin_routing;
    // Clock, reset and bus
    logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    // Channel outputs
    logic [11:0] chanMode;
    logic [5:0] chanDuty;
    logic [47:0] chanData;
    logic [8:0] chanTimerSel;
    // Pin side, {B3, E7, C1}
    logic chan2OutLevel, chan2CaptureIn, engineLevel;
    logic [2:0] pinIn, pinLevel, pinDirOut, owned, pinData;
    int fails, tests_run;
    // The one slave answers the bus
    assign hready = hreadyout;
    ccp_timer_and_pin_routing ccp_timer_and_pin_routing_i (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .chanMode(chanMode),
        .chanDuty(chanDuty), .chanData(chanData),
        .chanTimerSel(chanTimerSel), .chan2OutLevel(chan2OutLevel),
        .chan2CaptureIn(chan2CaptureIn), .portcPin1In(pinIn[0]),
        .portePin7In(pinIn[1]), .portbPin3In(pinIn[2]),
        .portcPin1Owned(owned[0]), .portePin7Owned(owned[1]),
        .portbPin3Owned(owned[2]), .portcPin1Data(pinData[0]),
        .portePin7Data(pinData[1]), .portbPin3Data(pinData[2]));
    ccp_far_side_model ccp_far_side_model_i (
        .clk_sys(clk_sys), .pinLevel(pinLevel), .pinDirOut(pinDirOut),
        .engineLevel(engineLevel), .pinData(pinData), .pinIn(pinIn),
        .chan2OutLevel(chan2OutLevel));
    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic chk(input string n, input logic [47:0] s, e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic waitReady;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask
    // One single word transfer
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge clk_sys); // Start right after a rising edge
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= ccp_route_pkg::HSIZE_WORD;
        htrans <= ccp_route_pkg::HTRANS_NONSEQ;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        r = hrdata;
    endtask
    // Byte address of a register index
    function automatic logic [31:0] ad(input logic [3:0] i);
        return {26'h0, i, 2'h0};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rdchk(input string n, input logic [31:0] a,
                         input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(n, {16'h0, r}, {40'h0, e});
    endtask
    // Let routing flops follow a register change
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys); // Sample mid-cycle, away from the edge
    endtask
    // Expected timer of a capture/compare channel per select
    function automatic logic [2:0] expTmr(input int s, c);
        if (s == 0) return ccp_route_pkg::TMR_1;
        if (s == 3) return ccp_route_pkg::TMR_3;
        if (s == 1) return (c == 0) ? ccp_route_pkg::TMR_1
                                    : ccp_route_pkg::TMR_3;
        return (c == 2) ? ccp_route_pkg::TMR_3 : ccp_route_pkg::TMR_1;
    endfunction
    // Reset values of every register and of the routing
    task automatic t_reset;
        for (int i = 0; i < 11; i++) begin
            rdchk("reset", ad(4'(i)), (i == 10) ? 8'h01 : 8'h00);
        end
        rdchk("status", ad(ccp_route_pkg::IDX_STATUS), 8'h11);
        chk("tsel", 48'(chanTimerSel), 48'h0);
        chk("owned", 48'(owned), 48'h1);
        chk("hresp", 48'(hresp), 48'h0);
    endtask
    // Channel registers: read, write, masks and port fields
    task automatic t_regs;
        for (int c = 0; c < 3; c++) begin
            wr(ad(4'(3 * c)), 8'(8'hE4 + c));
            wr(ad(4'(3 * c + 1)), 8'(8'hA0 + c));
            wr(ad(4'(3 * c + 2)), 8'(8'h50 + c));
            rdchk("ctrl", ad(4'(3 * c)), 8'(8'h24 + c));
            rdchk("low", ad(4'(3 * c + 1)), 8'(8'hA0 + c));
            rdchk("high", ad(4'(3 * c + 2)), 8'(8'h50 + c));
        end
        wr(32'h30, 8'hFF);
        wr(ad(ccp_route_pkg::IDX_STATUS), 8'hFF);
        rdchk("unmapped", 32'h30, 8'h00);
        rdchk("status ro", ad(ccp_route_pkg::IDX_STATUS), 8'h11);
        settle();
        for (int c = 0; c < 3; c++) begin
            chk("mode", 48'(chanMode[4*c+:4]), 48'(4 + c));
            chk("duty", 48'(chanDuty[2*c+:2]), 48'h2);
            chk("data", 48'(chanData[16*c+:16]),
                48'({8'(8'h50 + c), 8'(8'hA0 + c)}));
        end
    endtask
    // Four routings, then PWM and off channels
    task automatic t_route;
        logic [7:0] t3;
        for (int c = 0; c < 3; c++) wr(ad(4'(3 * c)), 8'h04);
        for (int s = 0; s < 4; s++) begin
            t3 = 8'h81 | (8'(s / 2) << ccp_route_pkg::T3_SEL_HI_BIT)
                 | (8'(s % 2) << ccp_route_pkg::T3_SEL_LO_BIT);
            wr(ad(ccp_route_pkg::IDX_T3_CTRL), t3);
            rdchk("t3", ad(ccp_route_pkg::IDX_T3_CTRL), t3);
            rdchk("route", ad(ccp_route_pkg::IDX_STATUS),
                  8'h10 | 8'(1 << s));
            settle();
            for (int c = 0; c < 3; c++) begin
                chk("tsel", 48'(chanTimerSel[3*c+:3]),
                    48'(expTmr(s, c)));
            end
        end
        wr(ad(ccp_route_pkg::IDX_T3_CTRL), 8'h08);
        wr(ad(ccp_route_pkg::IDX_CH3_CTRL), 8'h0C);
        settle();
        chk("three", 48'(chanTimerSel), 48'h0A1);
        // Channel 2 in PWM leaves its routed capture timer
        wr(ad(ccp_route_pkg::IDX_CH2_CTRL), 8'h0C);
        settle();
        chk("pwm2", 48'(chanTimerSel[5:3]), 48'h2);
        wr(ad(ccp_route_pkg::IDX_CH2_CTRL), 8'h00);
        settle();
        chk("off pwm", 48'(chanTimerSel), 48'h081);
    endtask
    // Channel-2 pin choice for each configuration
    task automatic t_pin;
        logic [7:0] cfg[5] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h06};
        logic [2:0] pin[5] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h4};
        for (int i = 0; i < 5; i++) begin
            wr(ad(ccp_route_pkg::IDX_CONFIG), cfg[i]);
            rdchk("cfg", ad(ccp_route_pkg::IDX_CONFIG), cfg[i]);
            pinLevel <= pin[i];
            engineLevel <= 1'b1;
            settle();
            chk("owned", 48'(owned), 48'(pin[i]));
            chk("pdata", 48'(pinData), 48'(pin[i]));
            chk("capt", 48'(chan2CaptureIn), 48'h1);
            @(posedge clk_sys); // Drive again on a rising edge
            pinLevel <= ~pin[i];
            engineLevel <= 1'b0;
            settle();
            chk("capt0", 48'(chan2CaptureIn), 48'h0);
            chk("pdata0", 48'(pinData), 48'h0);
        end
    endtask
    // Reset in mid-run restores the defaults
    task automatic t_reset2;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk("cfg rst", ad(ccp_route_pkg::IDX_CONFIG), 8'h01);
        rdchk("ctl rst", ad(ccp_route_pkg::IDX_CH3_CTRL), 8'h00);
        settle();
        chk("owned rst", 48'(owned), 48'h1);
    endtask
    // Main sequence
    initial begin
        fails = 0;
        tests_run = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        pinLevel = 3'h0;
        pinDirOut = 3'h0;
        engineLevel = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_route();
        t_pin();
        t_reset2();
        end_sim();
    end
endmodule
